//--- include/mieu_pkg.sv
// package of constants and types for the instruction execute unit
// What this block does
// (RULE1) jump loads the program counter from the instruction, flags unchanged
// (RULE2) move memory to accumulator copies the byte, flags unchanged
// (RULE3) move immediate loads the 8-bit constant into the accumulator, flags unchanged
// (RULE4) move accumulator to memory writes the accumulator into the byte, flags unchanged
// (RULE5) no-operation only advances the program counter by one
// (RULE6) OR with memory or immediate goes to the accumulator, only zero flag updates
// (RULE7) OR to memory writes the OR result into the byte, only zero flag updates
// (RULE8) plain return pops the program counter, takes two cycles, flags unchanged
// (RULE9) return with value pops the counter and loads the constant into the accumulator
// (RULE10) interrupt return pops the counter and sets the global interrupt enable
// (RULE11) in-place left rotate moves bit 7 into bit 0, flags unchanged
// (RULE12) left rotate to accumulator leaves memory and flags unchanged
// (RULE13) left rotate through carry: old carry into bit 0, bit 7 into carry
// (RULE14) in-place right rotate moves bit 0 into bit 7, flags unchanged
// (RULE15) right rotate to accumulator leaves memory and flags unchanged
// (RULE16) right rotate through carry: old carry into bit 7, bit 0 into carry
// (RULE17) subtract with borrow is acc plus inverted byte plus carry, four flags update
// (RULE18) decrement-skip writes byte minus one, skips with dummy cycle when zero
// (RULE19) decrement-to-accumulator skip loads byte minus one, memory unchanged, skips on zero
// (RULE20) byte set writes all ones, bit set forces one bit, flags unchanged
// (RULE21) increment-skip writes byte plus one, skips with dummy cycle on zero
// (RULE22) increment-to-accumulator skip loads byte plus one, memory unchanged, skips on zero
// (RULE23) bit-set skip discards next instruction with dummy cycle when the bit is one
// (RULE24) the dummy cycle after a taken skip has no side effect but advancing
package mieu_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int ADDR_W = 8;
    localparam int BIT_W = 3;
    localparam int STACK_DEPTH = 6;
    localparam int SP_W = 3;
    localparam logic [SP_W-1:0] SP_LAST = 3'h5;
    localparam logic [SP_W-1:0] SP_RST = 3'h0;
    localparam logic [PC_W-1:0] PC_RST = 12'h000;
    localparam logic [PC_W-1:0] PC_ONE = 12'h001;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [DATA_W-1:0] BYTE_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic GIE_RST = 1'b0;
    localparam int MSB = 7;
    localparam int NIB = 4;

    typedef enum logic [4:0] {
        nop_op,
        jump_op,
        mov_acc_mem_op,
        mov_acc_imm_op,
        mov_mem_acc_op,
        or_mem_op,
        or_imm_op,
        or_to_mem_op,
        ret_op,
        ret_imm_op,
        interrupt_return_op,
        rotate_left_op,
        rotate_left_to_acc_op,
        rotate_left_carry_op,
        rotate_left_carry_acc_op,
        rotate_right_op,
        rotate_right_to_acc_op,
        rotate_right_carry_op,
        rotate_right_carry_acc_op,
        subtract_borrow_op,
        subtract_borrow_to_mem_op,
        decrement_skip_zero_op,
        decrement_to_acc_skip_op,
        set_byte_op,
        set_bit_op,
        increment_skip_zero_op,
        increment_to_acc_skip_op,
        bit_set_skip_op
    } mieu_op_e;

    typedef enum logic [1:0] {
        st_exec,
        st_ret_wait,
        st_dummy
    } mieu_state_e;
endpackage : mieu_pkg

//--- hdl/mieu_execute.sv
// execute stage: accumulator, flags, program counter and return stack
`timescale 1ns/1ps
module mieu_execute (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // decoded instruction from fetch/decode
    input wire logic op_valid,
    output logic op_ready,
    input wire mieu_pkg::mieu_op_e op_code,
    input wire logic [mieu_pkg::ADDR_W-1:0] op_mem_addr,
    input wire logic [mieu_pkg::DATA_W-1:0] op_imm,
    input wire logic [mieu_pkg::BIT_W-1:0] op_bit,
    input wire logic [mieu_pkg::PC_W-1:0] op_target,
    // data memory
    output logic [mieu_pkg::ADDR_W-1:0] mem_raddr,
    input wire logic [mieu_pkg::DATA_W-1:0] mem_rdata,
    output logic mem_we,
    output logic [mieu_pkg::ADDR_W-1:0] mem_waddr,
    output logic [mieu_pkg::DATA_W-1:0] mem_wdata,
    // return stack fill from call and interrupt entry logic
    input wire logic stack_push,
    input wire logic [mieu_pkg::PC_W-1:0] stack_push_addr,
    // interrupt enable
    input wire logic gie_clear,
    output logic global_interrupt_enable,
    // architectural state
    output logic [mieu_pkg::PC_W-1:0] pc,
    output logic [mieu_pkg::DATA_W-1:0] working_accumulator,
    output logic flag_ov,
    output logic flag_z,
    output logic flag_ac,
    output logic flag_c,
    output logic fetch_discard
);

    function automatic logic is_skip_op(input mieu_pkg::mieu_op_e code);
        is_skip_op = (code == mieu_pkg::decrement_skip_zero_op) ||
                     (code == mieu_pkg::decrement_to_acc_skip_op) ||
                     (code == mieu_pkg::increment_skip_zero_op) ||
                     (code == mieu_pkg::increment_to_acc_skip_op) ||
                     (code == mieu_pkg::bit_set_skip_op);
    endfunction : is_skip_op

    function automatic logic is_return_op(input mieu_pkg::mieu_op_e code);
        is_return_op = (code == mieu_pkg::ret_op) ||
                       (code == mieu_pkg::ret_imm_op) ||
                       (code == mieu_pkg::interrupt_return_op);
    endfunction : is_return_op

    mieu_pkg::mieu_state_e state_q;
    mieu_pkg::mieu_state_e state_d;
    logic [mieu_pkg::PC_W-1:0] pc_q;
    logic [mieu_pkg::PC_W-1:0] pc_d;
    logic [mieu_pkg::DATA_W-1:0] acc_q;
    logic [mieu_pkg::DATA_W-1:0] acc_d;
    logic ov_q;
    logic ov_d;
    logic z_q;
    logic z_d;
    logic ac_q;
    logic ac_d;
    logic c_q;
    logic c_d;
    logic gie_q;
    logic gie_d;
    logic we_q;
    logic we_d;
    logic [mieu_pkg::ADDR_W-1:0] waddr_q;
    logic [mieu_pkg::DATA_W-1:0] wdata_q;
    logic [mieu_pkg::DATA_W-1:0] wdata_d;
    logic [mieu_pkg::SP_W-1:0] sp_q;
    logic [mieu_pkg::SP_W-1:0] sp_d;
    logic [mieu_pkg::PC_W-1:0] stack_mem [mieu_pkg::STACK_DEPTH];

    // handshake and decode
    wire take = op_valid && op_ready;
    wire skip_kind = is_skip_op(op_code);
    wire ret_kind = is_return_op(op_code);

    // the write of the previous op is still in flight; forward it to avoid a stale read
    wire fwd_hit = we_q && (waddr_q == op_mem_addr);
    wire [mieu_pkg::DATA_W-1:0] operand = fwd_hit ? wdata_q : mem_rdata;

    // stack pointer neighbours, wrapping over the six levels
    wire [mieu_pkg::SP_W-1:0] sp_prev = (sp_q == mieu_pkg::SP_RST) ? mieu_pkg::SP_LAST
                                        : sp_q - 3'h1;
    wire [mieu_pkg::SP_W-1:0] sp_next = (sp_q == mieu_pkg::SP_LAST) ? mieu_pkg::SP_RST
                                        : sp_q + 3'h1;
    wire [mieu_pkg::PC_W-1:0] stack_top = stack_mem[sp_prev];
    wire [mieu_pkg::PC_W-1:0] pc_inc = pc_q + mieu_pkg::PC_ONE;

    // logic results
    wire [mieu_pkg::DATA_W-1:0] or_mem_res = acc_q | operand;
    wire [mieu_pkg::DATA_W-1:0] or_imm_res = acc_q | op_imm;

    // rotates
    wire [mieu_pkg::DATA_W-1:0] rot_l = {operand[mieu_pkg::MSB-1:0], operand[mieu_pkg::MSB]};
    wire [mieu_pkg::DATA_W-1:0] rot_lc = {operand[mieu_pkg::MSB-1:0], c_q};
    wire [mieu_pkg::DATA_W-1:0] rot_r = {operand[0], operand[mieu_pkg::MSB:1]};
    wire [mieu_pkg::DATA_W-1:0] rot_rc = {c_q, operand[mieu_pkg::MSB:1]};

    // subtract with borrow as acc + ~m + c
    wire [mieu_pkg::DATA_W-1:0] inv_m = ~operand;
    wire [mieu_pkg::DATA_W:0] sbc_sum = {1'b0, acc_q} + {1'b0, inv_m} + {8'h00, c_q};
    wire [mieu_pkg::NIB:0] sbc_low = {1'b0, acc_q[mieu_pkg::NIB-1:0]}
                                   + {1'b0, inv_m[mieu_pkg::NIB-1:0]} + {4'h0, c_q};
    wire [mieu_pkg::DATA_W-1:0] sbc_res = sbc_sum[mieu_pkg::DATA_W-1:0];
    wire sbc_ov = (acc_q[mieu_pkg::MSB] == inv_m[mieu_pkg::MSB]) &&
                  (sbc_res[mieu_pkg::MSB] != acc_q[mieu_pkg::MSB]);

    // increment, decrement and bit work
    wire [mieu_pkg::DATA_W-1:0] dec_res = operand - mieu_pkg::BYTE_ONE;
    wire [mieu_pkg::DATA_W-1:0] inc_res = operand + mieu_pkg::BYTE_ONE;
    wire dec_zero = (dec_res == mieu_pkg::BYTE_ZERO);
    wire inc_zero = (inc_res == mieu_pkg::BYTE_ZERO);
    wire [mieu_pkg::DATA_W-1:0] bit_mask = mieu_pkg::BYTE_ONE << op_bit;
    wire bit_is_one = |(operand & bit_mask);

    // skip decision for the five skip ops
    logic skip_taken;
    always_comb begin
        case (op_code)
            mieu_pkg::decrement_skip_zero_op,
            mieu_pkg::decrement_to_acc_skip_op: skip_taken = dec_zero; // RULE18 RULE19
            mieu_pkg::increment_skip_zero_op,
            mieu_pkg::increment_to_acc_skip_op: skip_taken = inc_zero; // RULE21 RULE22
            mieu_pkg::bit_set_skip_op: skip_taken = bit_is_one; // RULE23
            default: skip_taken = 1'b0;
        endcase
    end

    // next-state of the architectural registers
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        acc_d = acc_q;
        ov_d = ov_q;
        z_d = z_q;
        ac_d = ac_q;
        c_d = c_q;
        gie_d = gie_q;
        we_d = 1'b0;
        wdata_d = wdata_q;
        case (state_q)
            mieu_pkg::st_exec: begin
                if (take) begin
                    pc_d = pc_inc; // RULE5
                    case (op_code)
                        mieu_pkg::jump_op: pc_d = op_target; // RULE1
                        mieu_pkg::mov_acc_mem_op: acc_d = operand; // RULE2
                        mieu_pkg::mov_acc_imm_op: acc_d = op_imm; // RULE3
                        mieu_pkg::mov_mem_acc_op: begin
                            we_d = 1'b1; // RULE4
                            wdata_d = acc_q;
                        end
                        mieu_pkg::or_mem_op: begin
                            acc_d = or_mem_res; // RULE6
                            z_d = (or_mem_res == mieu_pkg::BYTE_ZERO);
                        end
                        mieu_pkg::or_imm_op: begin
                            acc_d = or_imm_res; // RULE6
                            z_d = (or_imm_res == mieu_pkg::BYTE_ZERO);
                        end
                        mieu_pkg::or_to_mem_op: begin
                            we_d = 1'b1; // RULE7
                            wdata_d = or_mem_res;
                            z_d = (or_mem_res == mieu_pkg::BYTE_ZERO);
                        end
                        mieu_pkg::ret_op: pc_d = stack_top; // RULE8
                        mieu_pkg::ret_imm_op: begin
                            pc_d = stack_top; // RULE9
                            acc_d = op_imm;
                        end
                        mieu_pkg::interrupt_return_op: begin
                            pc_d = stack_top; // RULE10
                            gie_d = 1'b1;
                        end
                        mieu_pkg::rotate_left_op: begin
                            we_d = 1'b1; // RULE11
                            wdata_d = rot_l;
                        end
                        mieu_pkg::rotate_left_to_acc_op: acc_d = rot_l; // RULE12
                        mieu_pkg::rotate_left_carry_op: begin
                            we_d = 1'b1; // RULE13
                            wdata_d = rot_lc;
                            c_d = operand[mieu_pkg::MSB];
                        end
                        mieu_pkg::rotate_left_carry_acc_op: begin
                            acc_d = rot_lc; // RULE13
                            c_d = operand[mieu_pkg::MSB];
                        end
                        mieu_pkg::rotate_right_op: begin
                            we_d = 1'b1; // RULE14
                            wdata_d = rot_r;
                        end
                        mieu_pkg::rotate_right_to_acc_op: acc_d = rot_r; // RULE15
                        mieu_pkg::rotate_right_carry_op: begin
                            we_d = 1'b1; // RULE16
                            wdata_d = rot_rc;
                            c_d = operand[0];
                        end
                        mieu_pkg::rotate_right_carry_acc_op: begin
                            acc_d = rot_rc; // RULE16
                            c_d = operand[0];
                        end
                        mieu_pkg::subtract_borrow_op,
                        mieu_pkg::subtract_borrow_to_mem_op: begin
                            ov_d = sbc_ov; // RULE17
                            z_d = (sbc_res == mieu_pkg::BYTE_ZERO);
                            ac_d = sbc_low[mieu_pkg::NIB];
                            c_d = sbc_sum[mieu_pkg::DATA_W];
                            if (op_code == mieu_pkg::subtract_borrow_op) begin
                                acc_d = sbc_res;
                            end else begin
                                we_d = 1'b1;
                                wdata_d = sbc_res;
                            end
                        end
                        mieu_pkg::decrement_skip_zero_op: begin
                            we_d = 1'b1; // RULE18
                            wdata_d = dec_res;
                        end
                        mieu_pkg::decrement_to_acc_skip_op: acc_d = dec_res; // RULE19
                        mieu_pkg::set_byte_op: begin
                            we_d = 1'b1; // RULE20
                            wdata_d = mieu_pkg::BYTE_ONES;
                        end
                        mieu_pkg::set_bit_op: begin
                            we_d = 1'b1; // RULE20
                            wdata_d = operand | bit_mask;
                        end
                        mieu_pkg::increment_skip_zero_op: begin
                            we_d = 1'b1; // RULE21
                            wdata_d = inc_res;
                        end
                        mieu_pkg::increment_to_acc_skip_op: acc_d = inc_res; // RULE22
                        default: ;
                    endcase
                    // returns hold the stage one more cycle, taken skips insert a dummy
                    if (ret_kind) begin
                        state_d = mieu_pkg::st_ret_wait; // RULE8
                    end else if (skip_kind && skip_taken) begin
                        state_d = mieu_pkg::st_dummy; // RULE18 RULE21 RULE23
                    end
                end
            end
            mieu_pkg::st_ret_wait: state_d = mieu_pkg::st_exec;
            mieu_pkg::st_dummy: begin
                pc_d = pc_inc; // RULE24
                state_d = mieu_pkg::st_exec;
            end
            default: state_d = mieu_pkg::st_exec;
        endcase
        // enable set by an interrupt return wins over a same-cycle clear
        if (gie_clear && !(take && op_code == mieu_pkg::interrupt_return_op)) begin
            gie_d = 1'b0;
        end
    end

    // return stack pointer: pop on any return taken, push from the call side
    wire pop = take && ret_kind;
    always_comb begin
        sp_d = sp_q;
        if (stack_push && !pop) begin
            sp_d = sp_next;
        end else if (pop && !stack_push) begin
            sp_d = sp_prev;
        end
    end

    // no reset on the stack contents; a pop from an empty stack returns garbage as in silicon
    always_ff @(posedge clk) begin
        if (stack_push) begin
            stack_mem[pop ? sp_prev : sp_q] <= stack_push_addr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= mieu_pkg::st_exec;
            pc_q <= mieu_pkg::PC_RST;
            acc_q <= mieu_pkg::ACC_RST;
            ov_q <= mieu_pkg::FLAG_RST;
            z_q <= mieu_pkg::FLAG_RST;
            ac_q <= mieu_pkg::FLAG_RST;
            c_q <= mieu_pkg::FLAG_RST;
            gie_q <= mieu_pkg::GIE_RST;
            sp_q <= mieu_pkg::SP_RST;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            acc_q <= acc_d;
            ov_q <= ov_d;
            z_q <= z_d;
            ac_q <= ac_d;
            c_q <= c_d;
            gie_q <= gie_d;
            sp_q <= sp_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            we_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= mieu_pkg::BYTE_ZERO;
        end else begin
            we_q <= we_d;
            waddr_q <= take ? op_mem_addr : waddr_q;
            wdata_q <= wdata_d;
        end
    end

    // outputs
    assign op_ready = (state_q == mieu_pkg::st_exec);
    assign fetch_discard = (state_q == mieu_pkg::st_dummy); // RULE24
    assign mem_raddr = op_mem_addr;
    assign mem_we = we_q;
    assign mem_waddr = waddr_q;
    assign mem_wdata = wdata_q;
    assign pc = pc_q;
    assign working_accumulator = acc_q;
    assign flag_ov = ov_q;
    assign flag_z = z_q;
    assign flag_ac = ac_q;
    assign flag_c = c_q;
    assign global_interrupt_enable = gie_q;

endmodule : mieu_execute

//--- verif/mieu_monitor.sv
// assertion checker bound to the execute unit ports
`timescale 1ns/1ps
module mieu_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire mieu_pkg::mieu_op_e op_code,
    input wire logic [7:0] op_mem_addr,
    input wire logic [7:0] op_imm,
    input wire logic [2:0] op_bit,
    input wire logic [11:0] op_target,
    input wire logic [7:0] mem_raddr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_we,
    input wire logic [7:0] mem_waddr,
    input wire logic [7:0] mem_wdata,
    input wire logic stack_push,
    input wire logic [11:0] stack_push_addr,
    input wire logic gie_clear,
    input wire logic global_interrupt_enable,
    input wire logic [11:0] pc,
    input wire logic [7:0] working_accumulator,
    input wire logic flag_ov,
    input wire logic flag_z,
    input wire logic flag_ac,
    input wire logic flag_c,
    input wire logic fetch_discard
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic taken;
    logic fresh;
    logic [3:0] flags;
    assign taken = op_valid && op_ready;
    // a write still in flight means mem_rdata is stale, so those cycles are not judged
    assign fresh = !mem_we || (mem_waddr != mem_raddr);
    assign flags = {flag_ov, flag_z, flag_ac, flag_c};
    sequence ret_taken;
        taken && (op_code inside {mieu_pkg::ret_op, mieu_pkg::ret_imm_op,
            mieu_pkg::interrupt_return_op});
    endsequence
    sequence dummy_then_ready;
        (fetch_discard && !op_ready) ##1 (op_ready && !fetch_discard);
    endsequence
    ret_stall_a: assert property (ret_taken |=> !op_ready ##1 op_ready)
        else $error("return did not take two cycles");
    dec_skip_a: assert property (taken && op_code == mieu_pkg::decrement_skip_zero_op
        && fresh && mem_rdata == 8'h01 |=> dummy_then_ready)
        else $error("decrement to zero did not skip");
    inc_noskip_a: assert property (taken && op_code == mieu_pkg::increment_skip_zero_op
        && fresh && mem_rdata != 8'hFF |=> op_ready && !fetch_discard)
        else $error("increment skipped on nonzero");
    bit_skip_a: assert property (taken && op_code == mieu_pkg::bit_set_skip_op
        && fresh && mem_rdata[op_bit] |=> dummy_then_ready)
        else $error("set bit did not skip");
    jump_load_a: assert property (taken && op_code == mieu_pkg::jump_op
        |=> pc == $past(op_target) && $stable(flags))
        else $error("jump target or flags wrong");
    imm_load_a: assert property (taken && op_code == mieu_pkg::mov_acc_imm_op
        |=> working_accumulator == $past(op_imm) && $stable(flags))
        else $error("immediate load wrong");
    store_acc_a: assert property (taken && op_code == mieu_pkg::mov_mem_acc_op
        |=> mem_we && mem_wdata == $past(working_accumulator) && mem_waddr == $past(op_mem_addr))
        else $error("accumulator store wrong");
    nop_step_a: assert property (taken && op_code == mieu_pkg::nop_op
        |=> pc == $past(pc) + 12'h001 && $stable(working_accumulator) && !mem_we)
        else $error("no-operation changed state");
    interrupt_return_op_enable_a: assert property (taken && op_code == mieu_pkg::interrupt_return_op
        |=> global_interrupt_enable)
        else $error("interrupt return left enable low");
    set_byte_a: assert property (taken && op_code == mieu_pkg::set_byte_op
        |=> mem_we && mem_wdata == 8'hFF)
        else $error("byte set wrong");
    rot_left_a: assert property (taken && op_code == mieu_pkg::rotate_left_op && fresh
        |=> mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
        else $error("left rotate wrong");
    dummy_quiet_a: assert property (fetch_discard |=> pc == $past(pc) + 12'h001
        && $stable(working_accumulator) && $stable(flags) && !mem_we)
        else $error("dummy cycle had a side effect");
endmodule : mieu_monitor

bind mieu_execute mieu_monitor u_mon (.*);

//--- verif/mieu_data_mem.sv
// behavioural data memory on the far side of the execute unit
`timescale 1ns/1ps
module mieu_data_mem (
    // clock
    input wire logic clk,
    // combinational read port
    input wire logic [7:0] mem_raddr,
    output logic [7:0] mem_rdata,
    // write port, one strobe per byte
    input wire logic mem_we,
    input wire logic [7:0] mem_waddr,
    input wire logic [7:0] mem_wdata
);
    logic [7:0] store_q [256];
    // pattern, zero only at address 221, shows a missed read
    initial begin
        for (int i = 0; i < 256; i++) store_q[i] = 8'((i * 59 + 17) & 255);
    end
    assign mem_rdata = store_q[mem_raddr];
    always @(posedge clk) begin
        if (mem_we) store_q[mem_waddr] <= mem_wdata;
    end
endmodule : mieu_data_mem

//--- verif/mieu_execute_test.sv
// self-checking bench for the execute unit against an integer model
`timescale 1ns/1ps
module mieu_execute_test;
    logic clk, rst_n, op_valid, op_ready, mem_we, stack_push, gie_clear;
    logic global_interrupt_enable, flag_ov, flag_z, flag_ac, flag_c, fetch_discard;
    mieu_pkg::mieu_op_e op_code;
    logic [7:0] op_mem_addr, op_imm, mem_raddr, mem_rdata, mem_waddr, mem_wdata;
    logic [7:0] working_accumulator;
    logic [2:0] op_bit;
    logic [11:0] op_target, stack_push_addr, pc;
    int fail_count, comparisons, k, v, x;
    int m_mem[256];
    int m_stk[$];
    int m_acc, m_pc, m_ov, m_z, m_ac, m_c, m_gie, w_pend, w_addr, w_data;

    mieu_execute uut (.*);
    mieu_data_mem u_mem (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // write strobe shows the cycle after the take
    task automatic edge_check;
        check("mem_we", {11'h0, mem_we}, 12'(w_pend));
        if (w_pend != 0) begin
            check("mem_waddr", {4'h0, mem_waddr}, 12'(w_addr));
            check("mem_wdata", {4'h0, mem_wdata}, 12'(w_data));
        end
        w_pend = 0;
    endtask : edge_check

    task automatic model_op(input int k, input int a, input int x, input int b, input int t);
        int m, r, s, sk;
        m = m_mem[a];
        r = -1;
        sk = 0;
        m_pc = (m_pc + 1) % 4096;
        case (k)
            1: m_pc = t;
            2: m_acc = m;
            3: m_acc = x;
            4: r = m_acc;
            5, 6: begin
                m_acc = m_acc | ((k == 5) ? m : x);
                m_z = (m_acc == 0);
            end
            7: begin
                r = m_acc | m;
                m_z = (r == 0);
            end
            8, 9, 10: begin
                m_pc = m_stk.pop_back();
                if (k == 9) m_acc = x;
                if (k == 10) m_gie = 1;
            end
            11, 12: s = ((m << 1) | (m >> 7)) & 255;
            13, 14: begin
                s = ((m << 1) | m_c) & 255;
                m_c = m >> 7;
            end
            15, 16: s = (m >> 1) | ((m & 1) << 7);
            17, 18: begin
                s = (m >> 1) | (m_c << 7);
                m_c = m & 1;
            end
            19, 20: begin
                s = m_acc + (255 - m) + m_c;
                m_ac = ((m_acc & 15) + (15 - (m & 15)) + m_c) > 15;
                m_ov = ((m_acc >> 7) != (m >> 7)) && (((s >> 7) & 1) != (m_acc >> 7));
                m_c = s >> 8;
                s = s & 255;
                m_z = (s == 0);
                if (k == 20) r = s;
                else m_acc = s;
            end
            21, 22, 25, 26: begin
                s = (k < 25) ? (m + 255) & 255 : (m + 1) & 255;
                sk = (s == 0);
                if (k % 2) r = s;
                else m_acc = s;
            end
            23: r = 255;
            24: r = m | (1 << b);
            27: sk = (m >> b) & 1;
            default: ;
        endcase
        if (k >= 11 && k <= 18) begin
            if (k % 2) r = s;
            else m_acc = s;
        end
        if (sk != 0) m_pc = (m_pc + 1) % 4096;
        if (r >= 0) begin
            m_mem[a] = r;
            w_pend = 1;
            w_addr = a;
            w_data = r;
        end
    endtask : model_op

    // held until taken
    task automatic issue(input int k, input int a, input int x);
        int b, t, n;
        b = $urandom % 8;
        t = $urandom % 4096;
        op_valid <= 1'b1;
        op_code <= mieu_pkg::mieu_op_e'(5'(k));
        op_mem_addr <= 8'(a);
        op_imm <= 8'(x);
        op_bit <= 3'(b);
        op_target <= 12'(t);
        n = 0;
        do begin
            @(posedge clk);
            edge_check();
            n++;
        end while (op_ready !== 1'b1 && n < 8);
        check("ready", {11'h0, op_ready}, 12'h001);
        check("acc", {4'h0, working_accumulator}, 12'(m_acc));
        check("pc", pc, 12'(m_pc));
        check("flags", {8'h0, flag_ov, flag_z, flag_ac, flag_c},
            12'(m_ov * 8 + m_z * 4 + m_ac * 2 + m_c));
        check("gie", {11'h0, global_interrupt_enable}, 12'(m_gie));
        model_op(k, a, x, b, t);
    endtask : issue

    task automatic idle(input int n);
        op_valid <= 1'b0;
        repeat (n) begin
            @(posedge clk);
            edge_check();
        end
    endtask : idle

    task automatic push_and_clear(input int a, input int clr);
        stack_push <= 1'b1;
        stack_push_addr <= 12'(a);
        gie_clear <= 1'(clr);
        @(posedge clk);
        edge_check();
        stack_push <= 1'b0;
        gie_clear <= 1'b0;
        m_stk.push_back(a);
        if (clr != 0) m_gie = 0;
    endtask : push_and_clear

    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        {op_valid, stack_push, gie_clear, op_code} = '0;
        {op_mem_addr, op_imm, op_bit, op_target, stack_push_addr} = '0;
        for (int i = 0; i < 256; i++) m_mem[i] = (i * 59 + 17) & 255;
        void'($urandom(97435));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // back to back into skips, forwarding meets the dummy
        issue(3, 0, 1);
        issue(4, 2, 0);
        issue(21, 2, 0);
        issue(3, 0, 255);
        issue(4, 3, 0);
        issue(25, 3, 0);
        issue(27, 3, 0);
        idle(2);
        push_and_clear(12'h123, 1);
        issue(10, 0, 0);
        for (int i = 0; i < 600; i++) begin
            k = $urandom % 28;
            if (k >= 8 && k <= 10 && m_stk.size() == 0) begin
                idle(2);
                push_and_clear($urandom % 4096, $urandom % 2);
            end
            v = $urandom % 4;
            x = (v == 0) ? 0 : (v == 1) ? 1 : (v == 2) ? 255 : $urandom % 256;
            issue(k, $urandom % 4, x);
        end
        idle(3);
        give_verdict();
    end
endmodule : mieu_execute_test
